// ### hdl/dcbuc_pkg.sv
package dcbuc_pkg;
  // byte addresses of the parallel register port; multi-byte fields sit msb first
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          MEM_BYTES       = 32;
  localparam int          OFS_PHASE_OFS1  = 32'h0000_0000;
  localparam int          OFS_PHASE_OFS2  = 32'h0000_0002;
  localparam int          OFS_START_TW    = 32'h0000_0004;
  localparam int          OFS_DELTA_FW    = 32'h0000_0010;
  localparam int          OFS_UPD_PERIOD  = 32'h0000_0016;
  localparam int          OFS_RAMP_RATE   = 32'h0000_001a;
  localparam int          OFS_MODE_CTRL   = 32'h0000_001f;
  localparam int          LEN_PHASE_OFS   = 2;
  localparam int          LEN_START_TW    = 6;
  localparam int          LEN_DELTA_FW    = 6;
  localparam int          LEN_UPD_PERIOD  = 4;
  localparam int          LEN_RAMP_RATE   = 3;
  localparam int          FREQ_W          = 48;
  localparam int          PHASE_W         = 14;
  localparam int          UPD_W           = 32;
  localparam int          RAMP_W          = 20;
  // mode_control field positions
  localparam int          CTRL_INT_UPDATE = 0;
  localparam int          CTRL_FULL_CLR   = 1;
  localparam int          CTRL_FREQ_CLR   = 2;
  localparam int          CTRL_MODE_LSB   = 3;
  localparam int          MODE_W          = 3;
  localparam logic [7:0]  CTRL_RESET      = 8'h01;
  localparam logic [2:0]  MODE_SINGLE     = 3'h0;
  localparam logic [2:0]  MODE_CHIRP      = 3'h3;
  localparam logic [2:0]  MODE_BPSK       = 3'h4;
  // update strobe high time in system clocks, and the period value below which the pin stays high
  localparam logic [3:0]  UPD_HIGH_CYCLES = 4'h8;
  localparam logic [31:0] UPD_STEADY_MIN  = 32'h0000_0005;
endpackage : dcbuc_pkg

// ### hdl/dcbuc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dcbuc_if;
  import dcbuc_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              upd_dev_o;
  logic              upd_dev_oe;
  logic              upd_host_o;
  logic              upd_host_oe;
  logic              upd_level;
  logic              key_pin;

  // wire level of the two-way update pin; weak pull-down when nobody drives
  assign upd_level = upd_dev_oe ? upd_dev_o : (upd_host_oe ? upd_host_o : 1'b0);

  modport device (input addr, wdata, wr, rd, upd_level, key_pin,
                  output rdata, upd_dev_o, upd_dev_oe);
  modport host   (output addr, wdata, wr, rd, upd_host_o, upd_host_oe, key_pin,
                  input rdata, upd_level);
endinterface : dcbuc_if
`default_nettype wire

// ### hdl/dcbuc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module dcbuc_sync (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : dcbuc_sync
`default_nettype wire

// ### hdl/dcbuc_device.sv
`timescale 1ns/1ns
`default_nettype none
module dcbuc_device (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  dcbuc_if.device                         bus,
  output logic [dcbuc_pkg::FREQ_W-1:0]    o_frequency,
  output logic [dcbuc_pkg::PHASE_W-1:0]   o_phase,
  output logic                            o_update_event
);
  import dcbuc_pkg::*;

  logic [DATA_W-1:0]  buf_mem [0:MEM_BYTES-1];
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  buf_mode;
  logic [FREQ_W-1:0]  buf_start_tw;
  logic [FREQ_W-1:0]  buf_delta_fw;
  logic [UPD_W-1:0]   buf_upd_n;
  logic [RAMP_W-1:0]  buf_ramp_n;
  logic [PHASE_W-1:0] buf_ph1;
  logic [PHASE_W-1:0] buf_ph2;
  logic [FREQ_W-1:0]  act_start_tw;
  logic [FREQ_W-1:0]  act_delta_fw;
  logic [RAMP_W-1:0]  act_ramp_n;
  logic [MODE_W-1:0]  act_mode;
  logic [PHASE_W-1:0] act_ph1;
  logic [PHASE_W-1:0] act_ph2;
  logic               upd_s;
  logic               upd_s_d;
  logic               key_s;
  logic               int_mode;
  logic               half_en;
  logic [UPD_W-1:0]   upd_cnt;
  logic               int_evt;
  logic               ext_rise;
  logic               upd_evt;
  logic [3:0]         hi_cnt;
  logic               upd_pin;
  logic               upd_oe;
  logic               full_clr;
  logic               fclr_bit;
  logic               fclr_bit_d;
  logic               fclr_pulse;
  logic               chirp;
  logic               hold;
  logic [RAMP_W-1:0]  ramp_cnt;
  logic               ramp_tick;
  logic [FREQ_W-1:0]  freq_acc;
  logic [FREQ_W-1:0]  phase_acc;
  logic [FREQ_W-1:0]  next_freq;
  logic [PHASE_W-1:0] phase_sel;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    int i;
    i = int'(a);
    mapped = (i < OFS_START_TW + LEN_START_TW)
           || (i >= OFS_DELTA_FW && i < OFS_RAMP_RATE + LEN_RAMP_RATE)
           || (i == OFS_MODE_CTRL);
  endfunction : mapped

  // gathers n bytes from base, first byte most significant
  function automatic logic [FREQ_W-1:0] gather(input int base, input int n);
    logic [FREQ_W-1:0] r;
    r = '0;
    for (int i = 0; i < n; i++) begin
      r = {r[FREQ_W-DATA_W-1:0], buf_mem[base+i]};
    end
    return r;
  endfunction : gather

  dcbuc_sync u_upd_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (bus.upd_level),
    .o_sync    (upd_s)
  );

  dcbuc_sync u_key_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (bus.key_pin),
    .o_sync    (key_s)
  );

  // buffer registers: written from the port; only the update period and the direction and clear bits reach the core before an update
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        buf_mem[i] <= (i == OFS_MODE_CTRL) ? CTRL_RESET : 8'h00;
      end
    end else if (bus.wr && mapped(bus.addr)) begin
      buf_mem[bus.addr[4:0]] <= bus.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_q <= 8'h00;
    end else if (bus.rd) begin
      rdata_q <= mapped(bus.addr) ? buf_mem[bus.addr[4:0]] : 8'h00;
    end
  end

  assign bus.rdata    = rdata_q;
  assign buf_mode     = buf_mem[OFS_MODE_CTRL];
  assign buf_start_tw = gather(OFS_START_TW, LEN_START_TW);
  assign buf_delta_fw = gather(OFS_DELTA_FW, LEN_DELTA_FW);
  assign buf_upd_n    = UPD_W'(gather(OFS_UPD_PERIOD, LEN_UPD_PERIOD));
  assign buf_ramp_n   = RAMP_W'(gather(OFS_RAMP_RATE, LEN_RAMP_RATE));
  assign buf_ph1      = PHASE_W'(gather(OFS_PHASE_OFS1, LEN_PHASE_OFS));
  assign buf_ph2      = PHASE_W'(gather(OFS_PHASE_OFS2, LEN_PHASE_OFS));

  // direction and clear bits act straight from the buffer so software can leave
  // external mode or release a clear without needing an update first
  assign int_mode = buf_mode[CTRL_INT_UPDATE];
  assign full_clr = buf_mode[CTRL_FULL_CLR];
  assign fclr_bit = buf_mode[CTRL_FREQ_CLR];

  // internal update timer runs on every other clock
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      half_en <= 1'b0;
    end else begin
      half_en <= ~half_en;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      upd_cnt <= 32'h0000_0000;
    end else if (!int_mode) begin
      upd_cnt <= buf_upd_n;
    end else if (half_en) begin
      upd_cnt <= (upd_cnt == 32'h0000_0000) ? buf_upd_n : upd_cnt - 32'h0000_0001;
    end
  end

  assign int_evt  = int_mode && half_en && (upd_cnt == 32'h0000_0000);
  assign ext_rise = !int_mode && upd_s && !upd_s_d;
  assign upd_evt  = int_evt || ext_rise;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      upd_s_d <= 1'b0;
    end else begin
      upd_s_d <= upd_s;
    end
  end

  // pin driver: one edge plus seven more held high
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hi_cnt <= 4'h0;
    end else if (int_evt) begin
      hi_cnt <= UPD_HIGH_CYCLES - 4'h1;
    end else if (hi_cnt != 4'h0) begin
      hi_cnt <= hi_cnt - 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      upd_pin <= 1'b0;
      upd_oe  <= 1'b0;
    end else begin
      upd_oe  <= int_mode;
      upd_pin <= int_mode && (int_evt || (hi_cnt != 4'h0)
                 || (buf_upd_n < UPD_STEADY_MIN));
    end
  end

  assign bus.upd_dev_o  = upd_pin;
  assign bus.upd_dev_oe = upd_oe;

  // transfer of buffered settings into the core
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      act_start_tw <= '0;
      act_delta_fw <= '0;
      act_ramp_n   <= '0;
      act_mode     <= MODE_SINGLE;
      act_ph1      <= '0;
      act_ph2      <= '0;
    end else if (upd_evt) begin
      act_start_tw <= buf_start_tw;
      act_delta_fw <= buf_delta_fw;
      act_ramp_n   <= buf_ramp_n;
      act_mode     <= buf_mode[CTRL_MODE_LSB +: MODE_W];
      act_ph1      <= buf_ph1;
      act_ph2      <= buf_ph2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fclr_bit_d <= 1'b0;
    end else begin
      fclr_bit_d <= fclr_bit;
    end
  end

  // a fresh write of the bit or any update while it stays set retriggers the clear
  assign fclr_pulse = (fclr_bit && !fclr_bit_d)
                   || (fclr_bit && upd_evt);

  assign chirp = (act_mode == MODE_CHIRP);
  assign hold  = chirp && key_s;

  // the reload value is only sampled at zero, so a new rate waits out the old count
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ramp_cnt <= '0;
    end else if (!hold) begin
      ramp_cnt <= (ramp_cnt == '0) ? act_ramp_n : ramp_cnt - RAMP_W'(1);
    end
  end

  assign ramp_tick = chirp && !hold && (ramp_cnt == '0);

  // two's complement add steps up or down; no bound is checked
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      freq_acc <= '0;
    end else if (full_clr) begin
      freq_acc <= '0;
    end else if (fclr_pulse) begin
      freq_acc <= '0;
    end else if (ramp_tick) begin
      freq_acc <= freq_acc + act_delta_fw;
    end
  end

  assign next_freq = act_start_tw + freq_acc;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_frequency <= '0;
      phase_acc   <= '0;
    end else if (full_clr) begin
      o_frequency <= '0;
      phase_acc   <= '0;
    end else begin
      o_frequency <= next_freq;
      phase_acc   <= phase_acc + o_frequency;
    end
  end

  assign phase_sel = (act_mode == MODE_BPSK && key_s) ? act_ph2 : act_ph1;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_phase        <= '0;
      o_update_event <= 1'b0;
    end else begin
      o_phase        <= phase_acc[FREQ_W-1 -: PHASE_W] + phase_sel;
      o_update_event <= upd_evt;
    end
  end
endmodule : dcbuc_device
`default_nettype wire

// ### hdl/dcbuc_host.sv
`timescale 1ns/1ns
`default_nettype none
module dcbuc_host (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  dcbuc_if.host                              bus,
  input  wire logic                          i_cmd_valid,
  input  wire logic                          i_cmd_write,
  input  wire logic [dcbuc_pkg::ADDR_W-1:0]  i_cmd_addr,
  input  wire logic [dcbuc_pkg::DATA_W-1:0]  i_cmd_wdata,
  output logic                               o_cmd_ready,
  output logic [dcbuc_pkg::DATA_W-1:0]       o_rd_data,
  output logic                               o_rd_valid,
  input  wire logic                          i_update_req,
  input  wire logic                          i_key_level
);
  import dcbuc_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE    = 3'b001,
    HS_STROBE  = 3'b010,
    HS_CAPTURE = 3'b100
  } dcbuc_hstate_e;

  dcbuc_hstate_e     state;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              wr_q;
  logic              rd_q;
  logic [3:0]        upd_cnt;
  logic              upd_o;
  logic              key_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state       <= HS_IDLE;
      addr_q      <= '0;
      wdata_q     <= '0;
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      o_cmd_ready <= 1'b1;
    end else begin
      case (state)
        HS_IDLE: begin
          if (i_cmd_valid) begin
            addr_q      <= i_cmd_addr;
            wdata_q     <= i_cmd_wdata;
            wr_q        <= i_cmd_write;
            rd_q        <= !i_cmd_write;
            o_cmd_ready <= 1'b0;
            state       <= HS_STROBE;
          end
        end
        HS_STROBE: begin
          wr_q <= 1'b0;
          rd_q <= 1'b0;
          if (rd_q) begin
            state <= HS_CAPTURE;
          end else begin
            o_cmd_ready <= 1'b1;
            state       <= HS_IDLE;
          end
        end
        HS_CAPTURE: begin
          o_cmd_ready <= 1'b1;
          state       <= HS_IDLE;
        end
        default: begin
          o_cmd_ready <= 1'b1;
          state       <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rd_data  <= '0;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= (state == HS_CAPTURE);
      if (state == HS_CAPTURE) begin
        o_rd_data <= bus.rdata;
      end
    end
  end

  // external update pulse; the user only requests it with internal mode off
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      upd_cnt <= 4'h0;
      upd_o   <= 1'b0;
      key_q   <= 1'b0;
    end else begin
      key_q <= i_key_level;
      if (i_update_req) begin
        upd_cnt <= UPD_HIGH_CYCLES - 4'h1;
        upd_o   <= 1'b1;
      end else if (upd_cnt != 4'h0) begin
        upd_cnt <= upd_cnt - 4'h1;
      end else begin
        upd_o <= 1'b0;
      end
    end
  end

  assign bus.addr        = addr_q;
  assign bus.wdata       = wdata_q;
  assign bus.wr          = wr_q;
  assign bus.rd          = rd_q;
  assign bus.upd_host_o  = upd_o;
  assign bus.upd_host_oe = upd_o;
  assign bus.key_pin     = key_q;
endmodule : dcbuc_host
`default_nettype wire

// ### verif/dcbuc_props.sv
`timescale 1ns/1ns
`default_nettype none
module dcbuc_props (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  input  wire logic [dcbuc_pkg::ADDR_W-1:0] addr,
  input  wire logic [dcbuc_pkg::DATA_W-1:0] wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  input  wire logic [dcbuc_pkg::DATA_W-1:0] rdata,
  input  wire logic                         upd_dev_o,
  input  wire logic                         upd_dev_oe,
  input  wire logic                         upd_host_o,
  input  wire logic                         upd_host_oe,
  input  wire logic                         upd_level,
  input  wire logic                         key_pin
);
  import dcbuc_pkg::*;
  logic        int_sh;
  logic [31:0] n_sh;
  logic [5:0]  quiet;
  logic [7:0]  hi_cnt;
  logic [7:0]  lo_cnt;
  logic        unmapped;

  assign unmapped = (addr >= 6'h0a && addr <= 6'h0f) || addr == 6'h1d || addr == 6'h1e
                    || addr >= 6'h20;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) int_sh <= CTRL_RESET[CTRL_INT_UPDATE];
    else if (wr && addr == 6'h1f) int_sh <= wdata[CTRL_INT_UPDATE];
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) n_sh <= '0;
    else if (wr && addr >= 6'h16 && addr <= 6'h19) n_sh[8*(25-int'(addr)) +: 8] <= wdata;
  end

  // period checks only once new settings have surely reached the counter
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) quiet <= '0;
    else if (wr && addr >= 6'h16) quiet <= '0;
    else if (quiet != 6'h3f) quiet <= quiet + 6'h01;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else if (upd_dev_o) begin
      hi_cnt <= (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
      lo_cnt <= '0;
    end else begin
      lo_cnt <= (lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01;
      hi_cnt <= '0;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_pulse_eight_wide: assert property (
    $fell(upd_dev_o) && upd_dev_oe && int_sh && quiet == 6'h3f && n_sh >= 32'h0000_0005
    |-> hi_cnt == 8'h08) else $error("update pulse high time wrong");
  chk_pulse_holds_high: assert property (
    $rose(upd_dev_o) && upd_dev_oe |-> upd_dev_o[*8]) else $error("update pulse too short");
  chk_update_period_gap: assert property (
    $rose(upd_dev_o) && int_sh && quiet == 6'h3f && n_sh >= 32'h0000_0005
    && n_sh < 32'h0000_0064 |-> lo_cnt == 8'(2 * n_sh - 6)) else $error("update period wrong");
  chk_small_count_high: assert property (
    int_sh && n_sh < 32'h0000_0005 && quiet == 6'h3f |-> upd_dev_o && upd_dev_oe)
    else $error("update pin not steady high");
  chk_internal_drives_pin: assert property (
    int_sh[*4] |-> upd_dev_oe) else $error("device not driving update pin");
  chk_external_releases_pin: assert property (
    (!int_sh)[*4] |-> !upd_dev_oe) else $error("device drives pin in external mode");
  chk_unmapped_reads_zero: assert property (
    rd && unmapped |=> rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (
    !rd |=> $stable(rdata)) else $error("read data changed without read");
  chk_host_pulse_min: assert property (
    $rose(upd_host_oe && upd_host_o) |-> (upd_host_oe && upd_host_o)[*2])
    else $error("external update pulse too short");

  cover property ($rose(upd_dev_o) && n_sh >= 32'h0000_0005);
  cover property (rd && unmapped);
  cover property ($rose(upd_host_oe && upd_host_o));
endmodule : dcbuc_props
`default_nettype wire

// ### verif/test_dds_chirp_bpsk_update_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module test_dds_chirp_bpsk_update_ctrl;
  import dcbuc_pkg::*;
  localparam logic [7:0]  CHIRP = {2'h0, MODE_CHIRP, 3'h1};
  localparam logic [7:0]  SINGLE = {2'h0, MODE_SINGLE, 3'h0};
  localparam logic [47:0] S1 = 48'h0000_1000_0000;
  localparam logic [47:0] S2 = 48'h0000_2000_0000;
  logic              i_clk;
  logic              i_reset_n;
  logic              cmd_valid;
  logic              cmd_write;
  logic              cmd_ready;
  logic              rd_valid;
  logic              update_req;
  logic              key_level;
  logic              update_event;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] rbyte;
  logic [FREQ_W-1:0] frequency;
  logic [FREQ_W-1:0] f0;
  logic [PHASE_W-1:0] phase;
  int                bad_count;
  int                check_count;
  int                n;

  dcbuc_if bus_if ();
  dcbuc_device dcbuc_device_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus_if),
    .o_frequency(frequency), .o_phase(phase), .o_update_event(update_event));
  dcbuc_host dcbuc_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus_if),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
    .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_update_req(update_req), .i_key_level(key_level));
  dcbuc_props dcbuc_props_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .upd_dev_o(bus_if.upd_dev_o), .upd_dev_oe(bus_if.upd_dev_oe),
    .upd_host_o(bus_if.upd_host_o), .upd_host_oe(bus_if.upd_host_oe),
    .upd_level(bus_if.upd_level), .key_pin(bus_if.key_pin));

  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic timed_out;
    bad_count++;
    $display("wrong value at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  endtask : timed_out

  task automatic cycles(input int c);
    repeat (c) @(negedge i_clk);
  endtask : cycles

  // one command; a read leaves its byte in rbyte
  task automatic host_cmd(input logic write, input int a, input logic [7:0] d);
    int k;
    @(negedge i_clk);
    cmd_valid = 1'b1;
    cmd_write = write;
    cmd_addr = ADDR_W'(a);
    cmd_wdata = d;
    for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge i_clk);
    if (k == 20) timed_out();
    @(posedge i_clk);
    @(negedge i_clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 20 && !write && rd_valid !== 1'b1; k++) @(negedge i_clk);
    if (k == 20) timed_out();
    rbyte = rd_data;
  endtask : host_cmd

  task automatic rd_chk(input int a, input logic [7:0] exp);
    host_cmd(1'b0, a, 8'h00);
    `CHECK(rbyte, exp);
  endtask : rd_chk

  // multi-byte fields go msb first, lowest address first
  task automatic wr_field(input int a, input int len, input logic [47:0] v);
    for (int i = 0; i < len; i++) host_cmd(1'b1, a + i, v[8*(len-1-i) +: 8]);
  endtask : wr_field

  task automatic step_chk(input int gap, input logic [47:0] exp);
    f0 = frequency;
    cycles(gap);
    `CHECK(frequency - f0, exp);
  endtask : step_chk

  task automatic wait_event;
    int k;
    for (k = 0; k < 200 && update_event !== 1'b1; k++) @(negedge i_clk);
    if (k == 200) timed_out();
  endtask : wait_event

  initial begin
    i_reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    update_req = 1'b0;
    key_level = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    cycles(70);
    rd_chk(OFS_MODE_CTRL, CTRL_RESET);
    host_cmd(1'b1, 'h0c, 8'h5a);
    rd_chk('h0c, 8'h00);
    rd_chk('h25, 8'h00);
    host_cmd(1'b1, OFS_START_TW + 5, 8'ha5);
    rd_chk(OFS_START_TW + 5, 8'ha5);
    $display("test registers done");
    wr_field(OFS_START_TW, LEN_START_TW, S1);
    wr_field(OFS_DELTA_FW, LEN_DELTA_FW, 48'h0000_0000_0010);
    wr_field(OFS_RAMP_RATE, LEN_RAMP_RATE, 48'h0000_0000_0003);
    host_cmd(1'b1, OFS_MODE_CTRL, CHIRP);
    cycles(12);
    step_chk(4, 48'h0000_0000_0010);
    step_chk(8, 48'h0000_0000_0020);
    wr_field(OFS_DELTA_FW, LEN_DELTA_FW, 48'hffff_ffff_fff0);
    cycles(12);
    step_chk(4, 48'hffff_ffff_fff0);
    wr_field(OFS_DELTA_FW, LEN_DELTA_FW, 48'h0000_0000_0000);
    cycles(12);
    step_chk(8, 48'h0000_0000_0000);
    wr_field(OFS_DELTA_FW, LEN_DELTA_FW, 48'h0000_0000_0010);
    key_level = 1'b1;
    cycles(12);
    step_chk(8, 48'h0000_0000_0000);
    key_level = 1'b0;
    cycles(12);
    step_chk(4, 48'h0000_0000_0010);
    wr_field(OFS_RAMP_RATE, LEN_RAMP_RATE, 48'h0000_0000_003f);
    cycles(140);
    f0 = frequency;
    for (n = 0; n < 100 && frequency === f0; n++) @(negedge i_clk);
    if (n == 100) timed_out();
    // a tick has just reloaded 63, so the new rate must wait out that count
    f0 = frequency;
    wr_field(OFS_RAMP_RATE, LEN_RAMP_RATE, 48'h0000_0000_0003);
    cycles(20);
    `CHECK(frequency, f0);
    cycles(50);
    `CHECK((frequency - f0) >= 48'h0000_0000_0020, 1'b1);
    $display("test chirp done");
    host_cmd(1'b1, OFS_MODE_CTRL, CHIRP | 8'h04);
    cycles(4);
    `CHECK((frequency - S1) < 48'h0000_0000_0020, 1'b1);
    cycles(11);
    `CHECK((frequency - S1) < 48'h0000_0000_0020, 1'b1);
    host_cmd(1'b1, OFS_MODE_CTRL, CHIRP | 8'h02);
    cycles(4);
    `CHECK(frequency, 48'h0000_0000_0000);
    wr_field(OFS_START_TW, LEN_START_TW, S2);
    cycles(8);
    `CHECK(frequency, 48'h0000_0000_0000);
    host_cmd(1'b1, OFS_MODE_CTRL, CHIRP);
    cycles(8);
    `CHECK((frequency - S2) < 48'h0000_0000_0100, 1'b1);
    $display("test clear done");
    wr_field(OFS_PHASE_OFS1, LEN_PHASE_OFS, 48'h0000_0000_0123);
    wr_field(OFS_PHASE_OFS2, LEN_PHASE_OFS, 48'h0000_0000_2345);
    host_cmd(1'b1, OFS_MODE_CTRL, {2'h0, MODE_BPSK, 3'h3});
    cycles(8);
    `CHECK(phase, 14'h0123);
    key_level = 1'b1;
    cycles(8);
    `CHECK(phase, 14'h2345);
    key_level = 1'b0;
    // next symbol in single tone: only offset one is rewritten
    host_cmd(1'b1, OFS_MODE_CTRL, SINGLE | 8'h03);
    wr_field(OFS_PHASE_OFS1, LEN_PHASE_OFS, 48'h0000_0000_0abc);
    cycles(8);
    `CHECK(phase, 14'h0abc);
    $display("test keying done");
    wr_field(OFS_START_TW, LEN_START_TW, S1);
    host_cmd(1'b1, OFS_MODE_CTRL, SINGLE | 8'h03);
    host_cmd(1'b1, OFS_MODE_CTRL, SINGLE | 8'h01);
    cycles(10);
    host_cmd(1'b1, OFS_MODE_CTRL, SINGLE);
    cycles(10);
    wr_field(OFS_START_TW, LEN_START_TW, S2);
    cycles(20);
    `CHECK(frequency, S1);
    update_req = 1'b1;
    @(negedge i_clk);
    update_req = 1'b0;
    wait_event();
    cycles(2);
    `CHECK(frequency, S2);
    $display("test external update done");
    wr_field(OFS_UPD_PERIOD, LEN_UPD_PERIOD, 48'h0000_0000_0006);
    host_cmd(1'b1, OFS_MODE_CTRL, SINGLE | 8'h01);
    cycles(80);
    wait_event();
    cycles(1);
    for (n = 1; n < 100 && update_event !== 1'b1; n++) @(negedge i_clk);
    `CHECK(n, 2 * (6 + 1));
    $display("test internal update done");
    test_done();
  end
endmodule : test_dds_chirp_bpsk_update_ctrl
`undef CHECK
`default_nettype wire
